// file: shared/dacc_consts.vh
// Constants for the dual channel converter control block
`ifndef DACC_CONSTS_VH
`define DACC_CONSTS_VH

// Register byte addresses on the Wishbone bus
`define DACC_ADDR_CODE0 4'h0
`define DACC_ADDR_CODE1 4'h4
`define DACC_ADDR_CTRL 4'h8
`define DACC_ADDR_STAT 4'hC

// Control register field positions
`define DACC_BIT_OE1 7
`define DACC_BIT_OE0 6
`define DACC_BIT_JOINT 5
`define DACC_RSVD_ONES 5'h1F

// Reset values
`define DACC_CODE_RST 8'h00
`define DACC_CTRL_RST 3'h0

// Settling interval: 10 us at 5 ns per cycle, longest time rounds down
`define DACC_SETTLE_NS 10000
`define DACC_CLK_NS 5
`define DACC_SETTLE_CYC (`DACC_SETTLE_NS / `DACC_CLK_NS)
`define DACC_CNT_W 12
// Counter load: settling cycles less one, at counter width
`define DACC_SETTLE_LOAD 12'h7CF

// Full-scale divisor of the code
`define DACC_FULL_SCALE 256

`endif

// file: hw/dacc_channel.v
// One converter channel: settling timer and held output
`timescale 1ns/1ps
`include "dacc_consts.vh"
module dacc_channel
(
    input wire clk,
    input wire rst_n,
    input wire enable,
    input wire code_write,
    input wire [7:0] code,
    output reg [7:0] out_code,
    output reg out_valid,
    output reg busy
);
    reg [`DACC_CNT_W-1:0] count;
    reg enable_q;
    wire start = (enable & ~enable_q) | (enable & code_write);
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_q <= 1'b0;
            count <= {`DACC_CNT_W{1'b0}};
            busy <= 1'b0;
            out_valid <= 1'b0;
            out_code <= `DACC_CODE_RST;
        end
        else
        begin
            enable_q <= enable;
            if (!enable)
            begin
                // Disabled channel drops its output
                busy <= 1'b0;
                out_valid <= 1'b0;
                count <= {`DACC_CNT_W{1'b0}};
            end
            else if (start)
            begin
                // New conversion on enable or code write
                busy <= 1'b1;
                out_valid <= 1'b0;
                count <= `DACC_SETTLE_LOAD;
            end
            else if (busy)
            begin
                if (count == {`DACC_CNT_W{1'b0}})
                begin
                    // Result presented only when count expires
                    busy <= 1'b0;
                    out_valid <= 1'b1;
                    out_code <= code;
                end
                else
                begin
                    count <= count - 1'b1;
                end
            end
            // Otherwise result holds steady
        end
    end
endmodule // dacc_channel

// file: hw/dacc_wb_slave.v
// Wishbone classic slave front end with single-cycle ack
`timescale 1ns/1ps
module dacc_wb_slave
(
    input wire clk,
    input wire rst_n,
    input wire cyc,
    input wire stb,
    input wire we,
    input wire sel0,
    output reg ack,
    output wire wr_strobe,
    output wire rd_strobe
);
    wire req = cyc & stb & ~ack;
    // Write lands at the edge where the master samples ack
    assign wr_strobe = cyc & stb & ack & we & sel0;
    assign rd_strobe = req & ~we;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ack <= 1'b0;
        else
            ack <= req;
    end
endmodule // dacc_wb_slave

// file: hw/dacc_top.v
// Dual channel 8-bit converter control with Wishbone register access
//
// Overview of operation
// - Two 8-bit read/write code registers, one per channel.
// - Control bit 5 joins both channels into one enable unit.
// - Control bits 4..0 read as one and ignore writes.
// - Joint off: only channels with their own enable convert.
// - Both convert if joint and any enable, or both enables.
// - Setting an enable starts conversion; output after settling interval, unless joint mode already converts that channel.
// - Code write on enabled channel restarts conversion immediately.
// - Output holds until code rewritten or enable cleared.
// - Clearing enable disables that channel output.
// - Output level is code divided by 256 times reference voltage.
// - Standby keeps output; software clears enables to save current.
`timescale 1ns/1ps
`include "dacc_consts.vh"
module dacc_top
(
    input wire CLK,
    input wire RSTN,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [3:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output wire WB_ACK_O,
    output reg [7:0] ANALOG_OUT_CH0,
    output reg [7:0] ANALOG_OUT_CH1,
    output reg OUT_EN_CH0,
    output reg OUT_EN_CH1
);
    // ****************************************
    // Bus front end
    // ****************************************
    wire wr_strobe;
    wire rd_strobe;
    dacc_wb_slave u_wb
    (
        .clk(CLK),
        .rst_n(RSTN),
        .cyc(WB_CYC_I),
        .stb(WB_STB_I),
        .we(WB_WE_I),
        .sel0(WB_SEL_I[0]),
        .ack(WB_ACK_O),
        .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe)
    );

    // ****************************************
    // Registers
    // ****************************************
    reg [7:0] channel0_code;
    reg [7:0] channel1_code;
    reg ch1_output_enable;
    reg ch0_output_enable;
    reg joint_enable;
    wire wr_code0 = wr_strobe & (WB_ADR_I == `DACC_ADDR_CODE0);
    wire wr_code1 = wr_strobe & (WB_ADR_I == `DACC_ADDR_CODE1);
    wire wr_ctrl = wr_strobe & (WB_ADR_I == `DACC_ADDR_CTRL);
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            channel0_code <= `DACC_CODE_RST;
            channel1_code <= `DACC_CODE_RST;
            {ch1_output_enable, ch0_output_enable, joint_enable} <= `DACC_CTRL_RST;
        end
        else
        begin
            if (wr_code0)
                channel0_code <= WB_DAT_I[7:0];
            if (wr_code1)
                channel1_code <= WB_DAT_I[7:0];
            if (wr_ctrl)
            begin
                ch1_output_enable <= WB_DAT_I[`DACC_BIT_OE1];
                ch0_output_enable <= WB_DAT_I[`DACC_BIT_OE0];
                joint_enable <= WB_DAT_I[`DACC_BIT_JOINT];
            end
        end
    end

    // ****************************************
    // Channel enable decode
    // ****************************************
    wire any_oe = ch0_output_enable | ch1_output_enable;
    wire both_on = (joint_enable & any_oe) | (ch0_output_enable & ch1_output_enable);
    wire conv_en0 = both_on | ch0_output_enable;
    wire conv_en1 = both_on | ch1_output_enable;

    // ****************************************
    // Channels
    // ****************************************
    wire [7:0] res0;
    wire [7:0] res1;
    wire valid0;
    wire valid1;
    wire busy0;
    wire busy1;
    dacc_channel u_ch0
    (
        .clk(CLK),
        .rst_n(RSTN),
        .enable(conv_en0),
        .code_write(wr_code0),
        .code(channel0_code),
        .out_code(res0),
        .out_valid(valid0),
        .busy(busy0)
    );
    dacc_channel u_ch1
    (
        .clk(CLK),
        .rst_n(RSTN),
        .enable(conv_en1),
        .code_write(wr_code1),
        .code(channel1_code),
        .out_code(res1),
        .out_valid(valid1),
        .busy(busy1)
    );

    // ****************************************
    // Pin outputs
    // ****************************************
    // Code drives an external ladder: level = code / 256 * reference
    // No standby input: output simply holds, standby-safe by design
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ANALOG_OUT_CH0 <= `DACC_CODE_RST;
            ANALOG_OUT_CH1 <= `DACC_CODE_RST;
            OUT_EN_CH0 <= 1'b0;
            OUT_EN_CH1 <= 1'b0;
        end
        else
        begin
            ANALOG_OUT_CH0 <= res0;
            ANALOG_OUT_CH1 <= res1;
            OUT_EN_CH0 <= valid0 & ch0_output_enable;
            OUT_EN_CH1 <= valid1 & ch1_output_enable;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    reg [31:0] next_rdata;
    always @*
    begin
        next_rdata = 32'h00000000;
        case (WB_ADR_I)
            `DACC_ADDR_CODE0: next_rdata[7:0] = channel0_code;
            `DACC_ADDR_CODE1: next_rdata[7:0] = channel1_code;
            `DACC_ADDR_CTRL: next_rdata[7:0] = {ch1_output_enable, ch0_output_enable, joint_enable,
                `DACC_RSVD_ONES};
            `DACC_ADDR_STAT: next_rdata[5:0] = {busy1, busy0, valid1, valid0, conv_en1, conv_en0};
            default: next_rdata = 32'h00000000;
        endcase
    end
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            WB_DAT_O <= 32'h00000000;
        else if (rd_strobe)
            WB_DAT_O <= next_rdata;
    end
endmodule // dacc_top

// file: dv/dacc_props_properties.sv
// Port-level checks for the converter control block
`timescale 1ns/1ps
`include "dacc_consts.vh"
module dacc_props
(
    input wire CLK,
    input wire RSTN,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [3:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    input wire [31:0] WB_DAT_O,
    input wire WB_ACK_O,
    input wire [7:0] ANALOG_OUT_CH0,
    input wire OUT_EN_CH0,
    input wire OUT_EN_CH1
);
    // ****************************************
    // Low-time counters and properties
    // ****************************************
    localparam int MIN_LOW = `DACC_SETTLE_CYC - 8;
    wire wr = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
    reg [11:0] low0;
    reg [11:0] low1;
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            low0 <= 12'h000;
            low1 <= 12'h000;
        end
        else
        begin
            low0 <= OUT_EN_CH0 ? 12'h000 : low0 + {11'h000, low0 != 12'hFFF};
            low1 <= OUT_EN_CH1 ? 12'h000 : low1 + {11'h000, low1 != 12'hFFF};
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
    ack_timing_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
    rsvd_read_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == `DACC_ADDR_CTRL
        |-> WB_DAT_O[4:0] == `DACC_RSVD_ONES) else $error("reserved bits not one");
    hold_out_a: assert property (OUT_EN_CH0 && $past(OUT_EN_CH0) |-> $stable(ANALOG_OUT_CH0))
        else $error("output moved while held");
    settle_ch0_a: assert property ($rose(OUT_EN_CH0) |-> low0 >= MIN_LOW) else $error("ch0 early");
    settle_ch1_a: assert property ($rose(OUT_EN_CH1) |-> low1 >= MIN_LOW) else $error("ch1 early");
    off_ch0_a: assert property (wr && WB_ADR_I == `DACC_ADDR_CTRL && !WB_DAT_I[`DACC_BIT_OE0]
        |-> ##[1:4] !OUT_EN_CH0) else $error("ch0 not disabled");
    off_ch1_a: assert property (wr && WB_ADR_I == `DACC_ADDR_CTRL && !WB_DAT_I[`DACC_BIT_OE1]
        |-> ##[1:4] !OUT_EN_CH1) else $error("ch1 not disabled");
    restart_ch0_a: assert property (wr && WB_ADR_I == `DACC_ADDR_CODE0 && OUT_EN_CH0
        |-> ##[1:4] !OUT_EN_CH0) else $error("ch0 no restart");
endmodule // dacc_props
bind dacc_top dacc_props i_dacc_props (.CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .ANALOG_OUT_CH0(ANALOG_OUT_CH0), .OUT_EN_CH0(OUT_EN_CH0), .OUT_EN_CH1(OUT_EN_CH1));

// file: dv/dacc_top_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "dacc_consts.vh"
module dacc_top_tb;
    // ****************************************
    // Stimulus, table and checks
    // ****************************************
    localparam int SET = `DACC_SETTLE_CYC;
    logic CLK = 1'b0, RSTN = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
    logic [3:0] WB_ADR_I = 4'h0, WB_SEL_I = 4'h0;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O;
    logic WB_ACK_O, OUT_EN_CH0, OUT_EN_CH1;
    logic [7:0] ANALOG_OUT_CH0, ANALOG_OUT_CH1, q;
    int n_mismatch = 0, checks_done = 0, cycles = 0;
    // Rows: enable bits 7..5, then conv1 conv0 en1 en0
    logic [6:0] rows [8] = '{7'h00, 7'h10, 7'h25, 7'h3D, 7'h4A, 7'h5E, 7'h6F, 7'h7F};
    dacc_top i_dacc_top (.CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
        .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
        .ANALOG_OUT_CH0(ANALOG_OUT_CH0), .ANALOG_OUT_CH1(ANALOG_OUT_CH1), .OUT_EN_CH0(OUT_EN_CH0),
        .OUT_EN_CH1(OUT_EN_CH1));
    initial forever #2.5 CLK = ~CLK;
    task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] d, input logic [3:0] sel);
        @(posedge CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= adr;
        WB_SEL_I <= sel;
        WB_DAT_I <= {24'h000000, d};
        do @(posedge CLK); while (WB_ACK_O !== 1'b1);
        q = WB_DAT_O[7:0];
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    initial
    begin
        repeat (2) @(posedge CLK);
        RSTN <= 1'b1;
        bus(1'b0, `DACC_ADDR_CTRL, 8'h00, 4'hF);
        chk("ctrl reset", 8'h1F, q);
        bus(1'b1, `DACC_ADDR_CODE0, 8'hA5, 4'hF);
        bus(1'b1, `DACC_ADDR_CODE1, 8'h3C, 4'hF);
        bus(1'b1, `DACC_ADDR_CODE0, 8'h77, 4'hE);
        bus(1'b0, `DACC_ADDR_CODE0, 8'h00, 4'hF);
        chk("code0", 8'hA5, q);
        bus(1'b0, `DACC_ADDR_CODE1, 8'h00, 4'hF);
        chk("code1", 8'h3C, q);
        bus(1'b0, 4'h2, 8'h00, 4'hF);
        chk("unmapped", 8'h00, q);
        foreach (rows[i])
        begin
            bus(1'b1, `DACC_ADDR_CTRL, 8'h00, 4'hF);
            bus(1'b1, `DACC_ADDR_CTRL, {rows[i][6:4], 5'h00}, 4'hF);
            repeat (SET + 8) @(posedge CLK);
            chk("en0", rows[i][0], OUT_EN_CH0);
            chk("en1", rows[i][1], OUT_EN_CH1);
            if (rows[i][0])
                chk("out0", 8'hA5, ANALOG_OUT_CH0);
            if (rows[i][1])
                chk("out1", 8'h3C, ANALOG_OUT_CH1);
            bus(1'b0, `DACC_ADDR_STAT, 8'h00, 4'hF);
            chk("conv", rows[i][3:2], q[1:0]);
            bus(1'b0, `DACC_ADDR_CTRL, 8'h00, 4'hF);
            chk("ctrl", {rows[i][6:4], 5'h1F}, q);
        end
        bus(1'b1, `DACC_ADDR_CODE0, 8'h5A, 4'hF);
        repeat (8) @(posedge CLK);
        chk("restart", 8'h00, OUT_EN_CH0);
        chk("ch1 held", 8'h01, OUT_EN_CH1);
        repeat (SET - 16) @(posedge CLK);
        chk("early", 8'h00, OUT_EN_CH0);
        repeat (24) @(posedge CLK);
        chk("new en", 8'h01, OUT_EN_CH0);
        chk("new out", 8'h5A, ANALOG_OUT_CH0);
        bus(1'b1, `DACC_ADDR_CTRL, 8'h40, 4'hF);
        repeat (8) @(posedge CLK);
        chk("ch1 off", 8'h00, OUT_EN_CH1);
        RSTN <= 1'b0;
        repeat (2) @(posedge CLK);
        chk("rst en0", 8'h00, OUT_EN_CH0);
        chk("rst out0", 8'h00, ANALOG_OUT_CH0);
        RSTN <= 1'b1;
        bus(1'b0, `DACC_ADDR_CODE0, 8'h00, 4'hF);
        chk("code0 rst", 8'h00, q);
        final_report();
    end
endmodule // dacc_top_tb
